/* File: core/i2cm_defs.vh */
// Constants for the two-wire master start, restart and transmit sequencer.
// Assumes inclusion by bare name from the design files under core/.
`ifndef I2CM_DEFS_VH
`define I2CM_DEFS_VH

// Control write field positions, low five bits of the second control register
`define I2CM_CTL_START_BIT   0
`define I2CM_CTL_RESTART_BIT 1
`define I2CM_CTL_LOW_W       5

// Instruction cycle is four sys_clk phases; counter steps on two of them
`define I2CM_PHASE_W         2
`define I2CM_PHASE_Q2        2'h1
`define I2CM_PHASE_Q4        2'h3

// Reset values and bit counter positions
`define I2CM_CNT_RST         7'h00
`define I2CM_STATE_RST       4'h0
`define I2CM_BIT_RST         4'h0
`define I2CM_LAST_DATA_BIT   4'h7
`define I2CM_ACK_BIT         4'h8

// Data buffer defaults
`define I2CM_DATA_W          8
`define I2CM_FIFO_DEPTH      32
`define I2CM_FIFO_AW         5

`endif

/* File: core/i2cm_fifo.v */
// Synchronous FIFO between software byte writes and the sequencer.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
module i2cm_fifo #(
   parameter W     = 8,
   parameter DEPTH = 32,
   parameter AW    = 5
) (
   input  wire          sys_clk,
   input  wire          rst,
   input  wire          in_valid,
   input  wire [W-1:0]  in_data,
   output wire          in_ready,
   output wire          out_valid,
   output wire [W-1:0]  out_data,
   input  wire          out_ready
);
   reg  [W-1:0] mem_q [0:DEPTH-1];
   reg  [AW-1:0] wptr_q;
   reg  [AW-1:0] rptr_q;
   reg  [AW:0]   count_q;
   reg           not_full_q;
   wire          push;
   wire          pop;
   wire [AW:0]   count_d;

   assign push      = in_valid & not_full_q;
   assign pop       = out_ready & (count_q != {(AW+1){1'b0}});
   assign in_ready  = not_full_q;
   assign out_valid = (count_q != {(AW+1){1'b0}});
   assign out_data  = mem_q[rptr_q];
   assign count_d   = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

   always @(posedge sys_clk) begin
      if (push) begin
         mem_q[wptr_q] <= in_data;
      end
   end

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wptr_q  <= {AW{1'b0}};
         rptr_q  <= {AW{1'b0}};
         count_q <= {(AW+1){1'b0}};
         not_full_q <= 1'b1;
      end else begin
         if (push) begin
            wptr_q <= wptr_q + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop) begin
            rptr_q <= rptr_q + {{(AW-1){1'b0}}, 1'b1};
         end
         count_q <= count_d;
         // Registered not-full keeps in_ready a clean flop output
         not_full_q <= (count_d != DEPTH[AW:0]);
      end
   end
endmodule // i2cm_fifo

/* File: core/i2cm_start_tx.v */
// Two-wire bus master: Start, Repeated Start and byte transmit with ack sampling.
// Assumes open-drain pins resolved outside; pin inputs are asynchronous to sys_clk.
`timescale 1ns/1ps
`include "i2cm_defs.vh"
module i2cm_start_tx #(
   parameter DW    = `I2CM_DATA_W,
   parameter DEPTH = `I2CM_FIFO_DEPTH,
   parameter AW    = `I2CM_FIFO_AW
) (
   input  wire          sys_clk,
   input  wire          rst,
   input  wire [6:0]    rate_reload_register,
   input  wire          ctl_wr,
   input  wire [4:0]    ctl_wdata,
   input  wire          buf_wr_valid,
   input  wire [DW-1:0] buf_wr_data,
   output wire          buf_wr_ready,
   input  wire          write_collision_clr,
   input  wire          bus_collision_clr,
   input  wire          port_interrupt_clr,
   input  wire          start_detected_clr,
   output reg           start_request_bit,
   output reg           restart_request_bit,
   output reg           buffer_full_flag,
   output reg           write_collision_flag,
   output reg           bus_collision_flag,
   output reg           ack_received_status,
   output reg           port_interrupt_flag,
   output reg           start_detected,
   input  wire          scl_i,
   output reg           scl_o,
   output reg           scl_oe,
   input  wire          sda_i,
   output reg           sda_o,
   output reg           sda_oe
);
   localparam [3:0] ST_IDLE    = 4'h0;
   localparam [3:0] ST_S_WAIT  = 4'h1;
   localparam [3:0] ST_S_HOLD  = 4'h2;
   localparam [3:0] ST_R_SCLLO = 4'h3;
   localparam [3:0] ST_R_SDAHI = 4'h4;
   localparam [3:0] ST_R_SCLRE = 4'h5;
   localparam [3:0] ST_R_HIGH  = 4'h6;
   localparam [3:0] ST_R_SDALO = 4'h7;
   localparam [3:0] ST_T_LOW   = 4'h8;
   localparam [3:0] ST_T_REL   = 4'h9;
   localparam [3:0] ST_T_HIGH  = 4'ha;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   reg                  scl_m_q;
   reg                  scl_s_q;
   reg                  scl_p_q;
   reg                  sda_m_q;
   reg                  sda_s_q;
   reg                  sda_p_q;

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         scl_m_q <= 1'b1;
         scl_s_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_m_q <= 1'b1;
         sda_s_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_m_q <= scl_i;
         scl_s_q <= scl_m_q;
         scl_p_q <= scl_s_q;
         sda_m_q <= sda_i;
         sda_s_q <= sda_m_q;
         sda_p_q <= sda_s_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data buffer FIFO
   wire                 fifo_valid;
   wire [DW-1:0]        fifo_data;
   wire                 fifo_pop;
   wire                 tx_busy;

   i2cm_fifo #(
      .W     (DW),
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_fifo (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .in_valid  (buf_wr_valid),
      .in_data   (buf_wr_data),
      .in_ready  (buf_wr_ready),
      .out_valid (fifo_valid),
      .out_data  (fifo_data),
      .out_ready (~tx_busy)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Bit-rate counter
   reg  [`I2CM_PHASE_W-1:0] phase_q;
   reg  [6:0]           cnt_q;
   reg                  run_q;
   reg  [3:0]           state_q;
   reg  [7:0]           shift_q;
   reg  [3:0]           bit_q;
   reg                  sda_pend_q;
   reg                  sda_next_q;
   wire                 tick;
   wire                 done;
   wire                 seq_busy;
   wire                 start_seen;

   // Period is reload plus one counter step, so a zero reload still works
   function [6:0] reload_val;
      input [6:0] rv;
      input       six_bits;
      begin
         reload_val = six_bits ? {1'b0, rv[5:0]} : rv;
      end
   endfunction

   assign tick       = (phase_q == `I2CM_PHASE_Q2) | (phase_q == `I2CM_PHASE_Q4);
   assign done       = run_q & tick & (cnt_q == 7'h00);
   assign tx_busy    = (state_q == ST_T_LOW) | (state_q == ST_T_REL) | (state_q == ST_T_HIGH);
   assign seq_busy   = start_request_bit | restart_request_bit;
   assign fifo_pop   = fifo_valid & ~tx_busy;
   assign start_seen = sda_p_q & ~sda_s_q & scl_s_q & scl_p_q;

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         phase_q <= {`I2CM_PHASE_W{1'b0}};
      end else begin
         phase_q <= phase_q + {{(`I2CM_PHASE_W-1){1'b0}}, 1'b1};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer
   task abort_seq;
      begin
         bus_collision_flag  <= 1'b1;
         start_request_bit   <= 1'b0;
         restart_request_bit <= 1'b0;
         run_q               <= 1'b0;
         scl_oe              <= 1'b0;
         sda_oe              <= 1'b0;
         state_q             <= ST_IDLE;
      end
   endtask

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         start_request_bit    <= 1'b0;
         restart_request_bit  <= 1'b0;
         run_q                <= 1'b0;
         cnt_q                <= `I2CM_CNT_RST;
         scl_oe               <= 1'b0;
         sda_oe               <= 1'b0;
         scl_o                <= 1'b0;
         sda_o                <= 1'b0;
         state_q              <= `I2CM_STATE_RST;
         shift_q              <= 8'h00;
         bit_q                <= `I2CM_BIT_RST;
         sda_pend_q           <= 1'b0;
         sda_next_q           <= 1'b0;
         buffer_full_flag     <= 1'b0;
         write_collision_flag <= 1'b0;
         bus_collision_flag   <= 1'b0;
         ack_received_status  <= 1'b0;
         port_interrupt_flag  <= 1'b0;
         start_detected       <= 1'b0;
      end else begin
         // Clears first so a same-cycle set below wins
         if (write_collision_clr) begin
            write_collision_flag <= 1'b0;
         end
         if (bus_collision_clr) begin
            bus_collision_flag <= 1'b0;
         end
         if (port_interrupt_clr) begin
            port_interrupt_flag <= 1'b0;
         end
         if (start_detected_clr) begin
            start_detected <= 1'b0;
         end
         if (start_seen) begin
            start_detected <= 1'b1;
         end
         if (run_q & tick & (cnt_q != 7'h00)) begin
            cnt_q <= cnt_q - 7'h01;
         end
         if (done) begin
            run_q <= 1'b0;
         end
         if (ctl_wr & ~seq_busy & (state_q == ST_IDLE)) begin
            restart_request_bit <= ctl_wdata[`I2CM_CTL_RESTART_BIT];
            start_request_bit   <= ctl_wdata[`I2CM_CTL_START_BIT] & ~ctl_wdata[`I2CM_CTL_RESTART_BIT];
         end
         if (fifo_pop) begin
            if (seq_busy | (state_q != ST_IDLE)) begin
               write_collision_flag <= 1'b1;
            end else begin
               shift_q          <= fifo_data;
               buffer_full_flag <= 1'b1;
               bit_q            <= `I2CM_BIT_RST;
               scl_oe           <= 1'b1;
               // MSB first, driven once the clock is low
               sda_next_q       <= ~fifo_data[7];
               sda_pend_q       <= 1'b1;
               cnt_q            <= reload_val(rate_reload_register, 1'b0);
               run_q            <= 1'b1;
               state_q          <= ST_T_LOW;
            end
         end
         case (state_q)
            ST_IDLE: begin
               if (start_request_bit) begin
                  if (~scl_s_q & ~sda_s_q) begin
                     abort_seq;
                  end else if (scl_s_q & sda_s_q) begin
                     cnt_q   <= reload_val(rate_reload_register, 1'b0);
                     run_q   <= 1'b1;
                     state_q <= ST_S_WAIT;
                  end
               end else if (restart_request_bit) begin
                  scl_oe  <= 1'b1;
                  state_q <= ST_R_SCLLO;
               end
            end
            ST_S_WAIT: begin
               if (~scl_s_q) begin
                  abort_seq;
               end else if (done) begin
                  if (sda_s_q) begin
                     sda_oe         <= 1'b1;
                     start_detected <= 1'b1;
                     cnt_q          <= reload_val(rate_reload_register, 1'b0);
                     run_q          <= 1'b1;
                     state_q        <= ST_S_HOLD;
                  end else begin
                     abort_seq;
                  end
               end
            end
            ST_S_HOLD: begin
               if (done) begin
                  start_request_bit   <= 1'b0;
                  port_interrupt_flag <= 1'b1;
                  state_q             <= ST_IDLE;
               end
            end
            ST_R_SCLLO: begin
               if (~scl_s_q & ~run_q) begin
                  sda_oe  <= 1'b0;
                  cnt_q   <= reload_val(rate_reload_register, 1'b1);
                  run_q   <= 1'b1;
                  state_q <= ST_R_SDAHI;
               end
            end
            ST_R_SDAHI: begin
               if (done & sda_s_q) begin
                  scl_oe  <= 1'b0;
                  state_q <= ST_R_SCLRE;
               end
            end
            ST_R_SCLRE: begin
               if (scl_s_q) begin
                  if (~sda_s_q) begin
                     abort_seq;
                  end else begin
                     cnt_q   <= reload_val(rate_reload_register, 1'b0);
                     run_q   <= 1'b1;
                     state_q <= ST_R_HIGH;
                  end
               end
            end
            ST_R_HIGH: begin
               if (~scl_s_q | ~sda_s_q) begin
                  abort_seq;
               end else if (done) begin
                  sda_oe  <= 1'b1;
                  cnt_q   <= reload_val(rate_reload_register, 1'b0);
                  run_q   <= 1'b1;
                  state_q <= ST_R_SDALO;
               end
            end
            ST_R_SDALO: begin
               if (done) begin
                  restart_request_bit <= 1'b0;
                  port_interrupt_flag <= 1'b1;
                  state_q             <= ST_IDLE;
               end
            end
            ST_T_LOW: begin
               if (sda_pend_q) begin
                  // Data moves a cycle after the fall, never with it
                  sda_oe     <= sda_next_q;
                  sda_pend_q <= 1'b0;
                  if (bit_q == `I2CM_ACK_BIT) begin
                     buffer_full_flag <= 1'b0;
                  end
               end
               if (done) begin
                  scl_oe  <= 1'b0;
                  state_q <= ST_T_REL;
               end
            end
            ST_T_REL: begin
               if (scl_s_q) begin
                  cnt_q   <= reload_val(rate_reload_register, 1'b0);
                  run_q   <= 1'b1;
                  state_q <= ST_T_HIGH;
               end
            end
            ST_T_HIGH: begin
               if (done) begin
                  scl_oe <= 1'b1;
                  if (bit_q == `I2CM_ACK_BIT) begin
                     ack_received_status <= sda_s_q;
                     port_interrupt_flag <= 1'b1;
                     state_q             <= ST_IDLE;
                  end else begin
                     if (bit_q == `I2CM_LAST_DATA_BIT) begin
                        sda_next_q <= 1'b0;
                     end else begin
                        sda_next_q <= ~shift_q[6];
                     end
                     sda_pend_q <= 1'b1;
                     shift_q <= {shift_q[6:0], 1'b0};
                     bit_q   <= bit_q + 4'h1;
                     cnt_q   <= reload_val(rate_reload_register, 1'b0);
                     run_q   <= 1'b1;
                     state_q <= ST_T_LOW;
                  end
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // i2cm_start_tx

/* File: verif/i2cm_properties.sv */
// Checker for the two-wire master sequencer, attached to its top by bind.
// Assumes one clock domain, sys_clk, and the asynchronous active-high reset rst.
`timescale 1ns/1ps
module i2cm_properties (
   input wire       sys_clk,
   input wire       rst,
   input wire       ctl_wr,
   input wire [4:0] ctl_wdata,
   input wire       start_request_bit,
   input wire       restart_request_bit,
   input wire       buffer_full_flag,
   input wire       bus_collision_flag,
   input wire       port_interrupt_flag,
   input wire       scl_oe,
   input wire       sda_oe
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////
   property p_rst_idle;
      $fell(rst) |-> !scl_oe && !sda_oe && !start_request_bit && !restart_request_bit;
   endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("lines or requests active after reset");
   property p_start_cause;
      $rose(start_request_bit) |-> $past(ctl_wr) && $past(ctl_wdata[0]);
   endproperty
   a_start_cause: assert property (p_start_cause) else $error("start request without write");
   // Restart only from an idle write, never queued behind a start
   property p_restart_idle;
      $rose(restart_request_bit) |-> $past(ctl_wr) && $past(ctl_wdata[1])
         && !$past(start_request_bit) && !$past(buffer_full_flag);
   endproperty
   a_restart_idle: assert property (p_restart_idle) else $error("restart taken while busy");
   property p_start_edge;
      $rose(sda_oe) && start_request_bit |-> !scl_oe;
   endproperty
   a_start_edge: assert property (p_start_edge) else $error("start edge with clock low");
   property p_start_done;
      $fell(start_request_bit) && !bus_collision_flag |-> sda_oe && !scl_oe;
   endproperty
   a_start_done: assert property (p_start_done) else $error("start ended without data held low");
   property p_collide;
      $rose(bus_collision_flag) |-> !scl_oe && !sda_oe && !start_request_bit && !restart_request_bit;
   endproperty
   a_collide: assert property (p_collide) else $error("collision left lines or requests active");
   property p_restart_end;
      $fell(restart_request_bit) && !bus_collision_flag |-> (sda_oe && !scl_oe) ##[0:1] port_interrupt_flag;
   endproperty
   a_restart_end: assert property (p_restart_end) else $error("restart end state wrong");
   property p_byte_bits;
      buffer_full_flag && $changed(sda_oe) |-> scl_oe;
   endproperty
   a_byte_bits: assert property (p_byte_bits) else $error("data changed with clock high");
   property p_ack_phase;
      $fell(buffer_full_flag) && !bus_collision_flag |-> !sda_oe && scl_oe;
   endproperty
   a_ack_phase: assert property (p_ack_phase) else $error("data not released after eighth bit");
   property p_byte_end;
      $rose(port_interrupt_flag) && !sda_oe |-> scl_oe && !buffer_full_flag;
   endproperty
   a_byte_end: assert property (p_byte_end) else $error("clock not held low after byte");
   ////////////////////////////////////////////////////////////////////////////
   c_start: cover property ($fell(start_request_bit) && sda_oe);
   c_restart: cover property ($fell(restart_request_bit));
   c_collide: cover property ($rose(bus_collision_flag));
endmodule // i2cm_properties

bind i2cm_start_tx i2cm_properties u_props (
   .sys_clk             (sys_clk),
   .rst                 (rst),
   .ctl_wr              (ctl_wr),
   .ctl_wdata           (ctl_wdata),
   .start_request_bit   (start_request_bit),
   .restart_request_bit (restart_request_bit),
   .buffer_full_flag    (buffer_full_flag),
   .bus_collision_flag  (bus_collision_flag),
   .port_interrupt_flag (port_interrupt_flag),
   .scl_oe              (scl_oe),
   .sda_oe              (sda_oe)
);

/* File: verif/i2cm_slave_model.sv */
// Behavioural slave on the two-wire bus: receives bytes, acknowledges, stretches.
// Assumes resolved open-drain line levels in; pull outputs high mean pull low.
`timescale 1ns/1ps
module i2cm_slave_model (
   input  wire       scl,
   input  wire       sda,
   input  wire       ack_en,
   input  wire       stretch,
   input  wire       jam,
   output wire       scl_pull,
   output wire       sda_pull,
   output reg  [7:0] rx_byte,
   output integer    rx_count,
   output integer    starts
);
   reg     [7:0] sr;
   reg           ack_q;
   reg           hold_q;
   integer       bitn;
   // Jam holds both lines low to force a collision
   assign scl_pull = hold_q | jam;
   assign sda_pull = ack_q | jam;
   initial begin
      rx_byte = 8'h00; rx_count = 0; starts = 0; sr = 8'h00; bitn = 0; ack_q = 0; hold_q = 0;
   end
   ////////////////////////////////////////////////////////////////////////////
   always @(negedge sda) begin
      if (scl === 1'b1 && !jam) begin
         bitn = 0;
         starts = starts + 1;
      end
   end
   always @(posedge scl) begin
      if (bitn < 8) begin
         sr = {sr[6:0], sda};
         bitn = bitn + 1;
      end else
         bitn = 9;
   end
   // Ack held a little past the ninth fall, since the master samples late
   always @(negedge scl) begin
      if (bitn == 8) begin
         rx_byte = sr;
         rx_count = rx_count + 1;
         ack_q = ack_en;
      end else if (bitn == 9) begin
         #10 ack_q = 0;
         bitn = 0;
      end
      if (stretch) begin
         hold_q = 1;
         #200 hold_q = 0;
      end
   end
endmodule // i2cm_slave_model

/* File: verif/testbench.sv */
// Self-checking bench for the two-wire master: start, restart, bytes, collision.
// Assumes a 200 MHz sys_clk; a reload of 3 gives a 90 ns bus clock.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module testbench;
   reg         sys_clk, rst, ctl_wr, buf_wr_valid, clr, ack_en, stretch, jam;
   reg   [4:0] ctl_wdata;
   reg   [6:0] rate;
   reg   [7:0] buf_wr_data;
   wire        buf_wr_ready, start_request_bit, restart_request_bit, buffer_full_flag;
   wire        write_collision_flag, bus_collision_flag, ack_received_status, port_interrupt_flag;
   wire        start_detected, scl_o, scl_oe, sda_o, sda_oe, scl_pull, sda_pull;
   wire  [7:0] rx_byte;
   wire [31:0] rx_count, starts;
   integer     failures, samples_checked, n, k;
   // Open-drain lines with pull-ups
   wire        scl = (scl_oe ? scl_o : 1'b1) & ~scl_pull;
   wire        sda = (sda_oe ? sda_o : 1'b1) & ~sda_pull;
   always #2.5 sys_clk = ~sys_clk;
   ////////////////////////////////////////////////////////////////////////////
   i2cm_start_tx #(.DEPTH(4), .AW(2)) DUT (
      .sys_clk(sys_clk), .rst(rst), .rate_reload_register(rate), .ctl_wr(ctl_wr),
      .ctl_wdata(ctl_wdata), .buf_wr_valid(buf_wr_valid), .buf_wr_data(buf_wr_data),
      .buf_wr_ready(buf_wr_ready), .write_collision_clr(clr), .bus_collision_clr(clr),
      .port_interrupt_clr(clr), .start_detected_clr(clr), .start_request_bit(start_request_bit),
      .restart_request_bit(restart_request_bit), .buffer_full_flag(buffer_full_flag),
      .write_collision_flag(write_collision_flag), .bus_collision_flag(bus_collision_flag),
      .ack_received_status(ack_received_status), .port_interrupt_flag(port_interrupt_flag),
      .start_detected(start_detected), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
      .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
   i2cm_slave_model u_slave (
      .scl(scl), .sda(sda), .ack_en(ack_en), .stretch(stretch), .jam(jam), .scl_pull(scl_pull),
      .sda_pull(sda_pull), .rx_byte(rx_byte), .rx_count(rx_count), .starts(starts));
   ////////////////////////////////////////////////////////////////////////////
   task cyc(input integer c);
      repeat (c) @(posedge sys_clk);
   endtask
   task ctl(input [4:0] v);
      @(posedge sys_clk); ctl_wr <= 1'b1; ctl_wdata <= v;
      @(posedge sys_clk); ctl_wr <= 1'b0;
   endtask
   // Valid and data held until ready is seen at an edge
   task push(input [7:0] b);
      integer t;
      begin
         @(posedge sys_clk); buf_wr_valid <= 1'b1; buf_wr_data <= b; t = 0;
         do begin @(posedge sys_clk); t++; end while (buf_wr_ready !== 1'b1 && t < 5000);
         buf_wr_valid <= 1'b0;
      end
   endtask
   task wait_int;
      integer t;
      begin
         t = 0;
         while (port_interrupt_flag !== 1'b1 && t < 5000) begin @(posedge sys_clk); t++; end
         `CHK("irq", 1'b1, port_interrupt_flag)
      end
   endtask
   // Extra edge lets the clear land before the next flag poll
   task clr_all;
      @(posedge sys_clk); clr <= 1'b1;
      @(posedge sys_clk); clr <= 1'b0;
      @(posedge sys_clk);
   endtask
   task summarize;
      if (failures == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #300000 failures++;
      summarize;
   end
   initial begin
      sys_clk = 0; rst = 1; ctl_wr = 0; ctl_wdata = 5'h00; buf_wr_valid = 0; buf_wr_data = 8'h00;
      clr = 0; ack_en = 1; stretch = 0; jam = 0; rate = 7'h0b; failures = 0; samples_checked = 0;
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      cyc(1);
      `CHK("idle", 5'h01, {scl_oe, sda_oe, start_request_bit, restart_request_bit, buf_wr_ready})
      `CHK("od", 2'b00, {scl_o, sda_o})
      ctl(5'h01); cyc(1);
      `CHK("start", 1'b1, start_request_bit)
      ctl(5'h02); cyc(1);
      `CHK("lock", 1'b0, restart_request_bit)
      push(8'h3c); cyc(3);
      `CHK("write_collision_flag", 1'b1, write_collision_flag)
      wait_int;
      `CHK("sdet", 1'b1, start_detected)
      `CHK("send", 4'h5, {start_request_bit, scl, sda, sda_oe})
      `CHK("starts", 32'd1, starts)
      clr_all; rate <= 7'h03;
      push(8'ha5); cyc(2);
      `CHK("full", 1'b1, buffer_full_flag)
      wait_int;
      `CHK("rx", 8'ha5, rx_byte)
      `CHK("ack", 4'h0, {ack_received_status, buffer_full_flag, scl, sda_oe})
      clr_all;
      ctl(5'h02); cyc(1);
      `CHK("rs", 1'b1, restart_request_bit)
      push(8'h11); cyc(3);
      `CHK("wcol2", 1'b1, write_collision_flag)
      wait_int;
      `CHK("rsend", 4'h7, {restart_request_bit, start_detected, sda_oe, scl})
      `CHK("starts2", 32'd2, starts)
      `CHK("rxn", 32'd1, rx_count)
      clr_all; ack_en <= 1'b0; stretch <= 1'b1;
      push(8'h5a);
      wait_int;
      `CHK("rx2", 8'h5a, rx_byte)
      `CHK("nack", 1'b1, ack_received_status)
      clr_all; ack_en <= 1'b1;
      // Fill while the slave stretches, until the buffer refuses
      @(posedge sys_clk); buf_wr_valid <= 1'b1; buf_wr_data <= 8'hc0; n = 0;
      while (n < 12) begin
         @(posedge sys_clk);
         if (buf_wr_ready !== 1'b1) break;
         n++;
         buf_wr_data <= 8'hc0 + n[7:0];
      end
      buf_wr_valid <= 1'b0;
      // Four queued plus one drained into the shifter before the refusal
      `CHK("refuse", 32'd5, n)
      for (k = 0; k < n; k++) begin
         wait_int;
         `CHK("rxq", 8'hc0 + k[7:0], rx_byte)
         clr_all;
      end
      `CHK("empty", 1'b1, buf_wr_ready)
      stretch <= 1'b0; jam <= 1'b1;
      cyc(4); ctl(5'h01); cyc(20);
      `CHK("bcol", 3'b100, {bus_collision_flag, start_request_bit, scl_oe})
      jam <= 1'b0;
      cyc(10);
      summarize;
   end
endmodule // testbench
